// ==== include/cacm_regs.svh ====
`ifndef CACM_REGS_SVH
`define CACM_REGS_SVH

// ==========================================================
// Register addresses on the special function register port
`define CACM_ADDR_RUN_FLAGS    8'hD8
`define CACM_ADDR_MODE         8'hD9

// ==========================================================
// Reset values
`define CACM_RST_RUN_FLAGS     8'h00
`define CACM_RST_MODE          8'h40
`define CACM_RST_COUNT         16'h0000

// ==========================================================
// Run and flag register bit positions
`define CACM_RF_OVERFLOW       7
`define CACM_RF_RUN            6
`define CACM_RF_EVT_HI         2
`define CACM_RF_EVT_LO         0
`define CACM_RF_WDT_EVT        2

// ==========================================================
// Mode register bit positions
`define CACM_MD_IDLE           7
`define CACM_MD_WDT_EN         6
`define CACM_MD_WDT_LOCK       5
`define CACM_MD_SEL_HI         3
`define CACM_MD_SEL_LO         1
`define CACM_MD_OVF_IE         0

// ==========================================================
// Timebase selector codes
`define CACM_SEL_DIV12         3'h0
`define CACM_SEL_DIV4          3'h1
`define CACM_SEL_TIMER0        3'h2
`define CACM_SEL_EXT_FALL      3'h3
`define CACM_SEL_SYSCLK        3'h4
`define CACM_SEL_EXT_DIV8      3'h5

// ==========================================================
// Divider and counter terminal counts
`define CACM_DIV12_LAST        4'hB
`define CACM_DIV4_LAST         2'h3
`define CACM_EXT_DIV8_LAST     3'h7
`define CACM_COUNT_ALL_ONES    16'hFFFF

`endif

// ==== include/cacm_pkg.sv ====
`include "cacm_regs.svh"

package cacm_pkg;

	// ==========================================================
	// Mode register layout, bit 7 first
	typedef struct packed {
		logic       idle_suspend;
		logic       watchdog_enable;
		logic       watchdog_lock;
		logic       unused4;
		logic [2:0] timebase_select;
		logic       overflow_irq_enable;
	} cacm_mode_t;

	// ==========================================================
	// Run and flag register layout, bit 7 first
	typedef struct packed {
		logic       counter_overflow_flag;
		logic       counter_run;
		logic [2:0] unused;
		logic [2:0] module_event_flag;
	} cacm_run_flags_t;

	// ==========================================================
	// Timebase sources offered to the counter
	typedef enum logic [2:0] {
		CACM_TB_DIV12    = `CACM_SEL_DIV12,
		CACM_TB_DIV4     = `CACM_SEL_DIV4,
		CACM_TB_TIMER0   = `CACM_SEL_TIMER0,
		CACM_TB_EXT_FALL = `CACM_SEL_EXT_FALL,
		CACM_TB_SYSCLK   = `CACM_SEL_SYSCLK,
		CACM_TB_EXT_DIV8 = `CACM_SEL_EXT_DIV8
	} cacm_tb_t;

endpackage

// ==== design/cacm_timebase.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "cacm_regs.svh"

module cacm_timebase (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       enable,
	input  wire logic [2:0] select,
	input  wire logic       timer0_overflow,
	input  wire logic       external_count_input,
	input  wire logic       external_clock,
	output logic            tick
);

	logic [3:0] div12_q, div12_d;
	logic [1:0] div4_q, div4_d;
	logic [2:0] ext8_q, ext8_d;
	logic       eci_prev_q, eci_prev_d;
	logic       ext_meta_q, ext_sync_q, ext_prev_q, ext_prev_d;
	logic       tick_q, tick_d;
	logic       ext_rise;

	assign tick = tick_q;

	// ==========================================================
	// Dividers hold while counting is off; the edge detectors keep sampling their inputs
	always_comb begin
		div12_d    = div12_q;
		div4_d     = div4_q;
		ext8_d     = ext8_q;
		eci_prev_d = external_count_input;
		ext_prev_d = ext_sync_q;
		ext_rise   = ext_sync_q & ~ext_prev_q;
		tick_d     = 1'b0;
		if (enable) begin
			div12_d = (div12_q == `CACM_DIV12_LAST) ? 4'h0 : div12_q + 4'h1;
			div4_d  = div4_q + 2'h1;
			if (ext_rise)
				ext8_d = ext8_q + 3'h1;
			case (select)
				`CACM_SEL_DIV12:    tick_d = (div12_q == `CACM_DIV12_LAST);
				`CACM_SEL_DIV4:     tick_d = (div4_q == `CACM_DIV4_LAST);
				`CACM_SEL_TIMER0:   tick_d = timer0_overflow;
				`CACM_SEL_EXT_FALL: tick_d = eci_prev_q & ~external_count_input;
				`CACM_SEL_SYSCLK:   tick_d = 1'b1;
				`CACM_SEL_EXT_DIV8: tick_d = ext_rise & (ext8_q == `CACM_EXT_DIV8_LAST);
				default:            tick_d = 1'b0;
			endcase
		end
	end

	// Registers, plus a two-flop sync of the external clock
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div12_q    <= 4'h0;
			div4_q     <= 2'h0;
			ext8_q     <= 3'h0;
			eci_prev_q <= 1'b1;
			ext_meta_q <= 1'b0;
			ext_sync_q <= 1'b0;
			ext_prev_q <= 1'b0;
			tick_q     <= 1'b0;
		end else begin
			div12_q    <= div12_d;
			div4_q     <= div4_d;
			ext8_q     <= ext8_d;
			eci_prev_q <= eci_prev_d;
			ext_meta_q <= external_clock;
			ext_sync_q <= ext_meta_q;
			ext_prev_q <= ext_prev_d;
			tick_q     <= tick_d;
		end
	end

endmodule
`default_nettype wire

// ==== design/cacm_top.sv ====

`timescale 1ns/10ps
`default_nettype none
`include "cacm_regs.svh"

module cacm_top #(
	parameter int COUNT_WIDTH = 16,
	parameter int MODULES     = 3
) (
	input  wire logic                   clk,
	input  wire logic                   reset_n,
	input  wire logic [7:0]             sfr_addr,
	input  wire logic                   sfr_write,
	input  wire logic [7:0]             sfr_wdata,
	output logic      [7:0]             sfr_rdata,
	input  wire logic [MODULES-1:0]     module_event,
	input  wire logic [MODULES-1:0]     module_irq_enable,
	input  wire logic                   cpu_idle,
	input  wire logic                   timer0_overflow,
	input  wire logic                   external_count_input,
	input  wire logic                   external_clock,
	output logic      [COUNT_WIDTH-1:0] counter_value,
	output logic                        counter_tick,
	output logic                        counter_active,
	output logic                        watchdog_enable,
	output logic                        watchdog_force_reset,
	output logic                        irq_request
);

	// ==========================================================
	// Declarations
	cacm_pkg::cacm_mode_t      mode_q, mode_d;
	cacm_pkg::cacm_run_flags_t rf_q, rf_d;
	logic [COUNT_WIDTH-1:0]    count_q, count_d;
	logic [7:0]                rdata_q, rdata_d;
	logic                      force_q, force_d;
	logic                      wr_mode, wr_rf;
	logic                      suspended;
	logic                      running;
	logic                      tb_tick;
	logic                      wrap;

	// Address decode helper, used by the write and read paths
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
		hit = (addr == target);
	endfunction

	assign wr_mode = sfr_write & hit(sfr_addr, `CACM_ADDR_MODE);
	assign wr_rf   = sfr_write & hit(sfr_addr, `CACM_ADDR_RUN_FLAGS);

	// ==========================================================
	// Run state
	// Idle suspension overrides everything, the watchdog forces running
	assign suspended = mode_q.idle_suspend & cpu_idle;
	assign running   = (rf_q.counter_run | mode_q.watchdog_enable) & ~suspended;

	// ==========================================================
	// Timebase tick source
	cacm_timebase i_cacm_timebase (
		.clk                  (clk),
		.reset_n              (reset_n),
		.enable               (running),
		.select               (mode_q.timebase_select),
		.timer0_overflow      (timer0_overflow),
		.external_count_input (external_count_input),
		.external_clock       (external_clock),
		.tick                 (tb_tick)
	);

	// ==========================================================
	// Counter
	// A tick that lands after the run state dropped is discarded
	assign wrap = running & tb_tick & (count_q == `CACM_COUNT_ALL_ONES);

	always_comb begin
		count_d = count_q;
		if (running && tb_tick)
			count_d = count_q + {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			count_q <= `CACM_RST_COUNT;
		else
			count_q <= count_d;
	end

	// ==========================================================
	// Mode register
	// Only the enable bit may change while the watchdog is on, and
	// only towards zero when the lock is clear
	always_comb begin
		mode_d = mode_q;
		if (wr_mode) begin
			if (mode_q.watchdog_enable) begin
				if (!mode_q.watchdog_lock)
					mode_d.watchdog_enable = sfr_wdata[`CACM_MD_WDT_EN];
			end else begin
				mode_d.idle_suspend        = sfr_wdata[`CACM_MD_IDLE];
				mode_d.watchdog_lock       = sfr_wdata[`CACM_MD_WDT_LOCK];
				mode_d.timebase_select     = sfr_wdata[`CACM_MD_SEL_HI:`CACM_MD_SEL_LO];
				mode_d.overflow_irq_enable = sfr_wdata[`CACM_MD_OVF_IE];
				// Setting the lock also turns the watchdog on
				mode_d.watchdog_enable     = sfr_wdata[`CACM_MD_WDT_EN] |
				                             sfr_wdata[`CACM_MD_WDT_LOCK];
			end
		end
		if (mode_q.watchdog_lock)
			mode_d.watchdog_enable = 1'b1;
		mode_d.unused4 = 1'b0;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			mode_q <= `CACM_RST_MODE;
		else
			mode_q <= mode_d;
	end

	// ==========================================================
	// Run bit and flags
	// Software may write either value; hardware only ever sets
	always_comb begin
		rf_d = rf_q;
		if (wr_rf) begin
			rf_d.counter_run           = sfr_wdata[`CACM_RF_RUN];
			rf_d.counter_overflow_flag = sfr_wdata[`CACM_RF_OVERFLOW];
			rf_d.module_event_flag     = sfr_wdata[`CACM_RF_EVT_HI:`CACM_RF_EVT_LO];
		end
		if (wrap)
			rf_d.counter_overflow_flag = 1'b1;
		rf_d.module_event_flag = rf_d.module_event_flag | module_event;
		rf_d.unused            = 3'h0;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			rf_q <= `CACM_RST_RUN_FLAGS;
		else
			rf_q <= rf_d;
	end

	// ==========================================================
	// Forced watchdog reset
	// Writing one to the module 2 flag while the watchdog runs
	always_comb begin
		force_d = wr_rf & mode_q.watchdog_enable & sfr_wdata[`CACM_RF_WDT_EVT];
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			force_q <= 1'b0;
		else
			force_q <= force_d;
	end

	// ==========================================================
	// Read path
	// Data appears one cycle after the address; unmapped reads zero
	always_comb begin
		rdata_d = 8'h00;
		if (hit(sfr_addr, `CACM_ADDR_MODE))
			rdata_d = mode_q;
		else if (hit(sfr_addr, `CACM_ADDR_RUN_FLAGS))
			rdata_d = rf_q;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			rdata_q <= 8'h00;
		else
			rdata_q <= rdata_d;
	end

	// ==========================================================
	// Outputs
	assign sfr_rdata            = rdata_q;
	assign counter_value        = count_q;
	assign counter_tick         = running & tb_tick;
	assign counter_active       = running;
	assign watchdog_enable      = mode_q.watchdog_enable;
	assign watchdog_force_reset = force_q;

	// Shared request: overflow when enabled and each enabled module flag
	assign irq_request = (rf_q.counter_overflow_flag & mode_q.overflow_irq_enable) |
	                     |(rf_q.module_event_flag & module_irq_enable);

endmodule
`default_nettype wire

// ==== dv/cacm_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Port watcher for the counter array control block
module cacm_assertions #(
	parameter int COUNT_WIDTH = 16,
	parameter int MODULES     = 3
) (
	input wire logic                   clk,
	input wire logic                   reset_n,
	input wire logic [7:0]             sfr_addr,
	input wire logic                   sfr_write,
	input wire logic [7:0]             sfr_wdata,
	input wire logic [7:0]             sfr_rdata,
	input wire logic [MODULES-1:0]     module_event,
	input wire logic [MODULES-1:0]     module_irq_enable,
	input wire logic                   cpu_idle,
	input wire logic [COUNT_WIDTH-1:0] counter_value,
	input wire logic                   counter_tick,
	input wire logic                   counter_active,
	input wire logic                   watchdog_enable,
	input wire logic                   irq_request
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// ==========================================================
	// Counter, enables and flags
	AST_HOLD: assert property (!counter_tick |=> $stable(counter_value))
		else $error("count moved without a tick");
	AST_ADV: assert property (counter_tick |=> counter_value == $past(counter_value) + 1'b1)
		else $error("count did not advance by one");
	AST_TICK_ACT: assert property ($rose(counter_active) |-> !counter_tick)
		else $error("stale tick used on restart");
	AST_WDT_RUN: assert property (watchdog_enable && !cpu_idle |-> counter_active)
		else $error("counter off while watchdog runs");
	AST_WDT_FELL: assert property ($fell(watchdog_enable)
		|-> $past(sfr_write && sfr_addr == 8'hD9 && !sfr_wdata[6]))
		else $error("watchdog dropped without a clearing write");
	AST_WDT_ROSE: assert property ($rose(watchdog_enable)
		|-> $past(sfr_write && sfr_addr == 8'hD9 && (sfr_wdata[6] || sfr_wdata[5])))
		else $error("watchdog rose without a write");
	AST_IRQ_EVT: assert property ((|(module_event & module_irq_enable)) ##1
		$stable(module_irq_enable) |-> irq_request)
		else $error("enabled event raised no request");
	AST_STICKY: assert property (irq_request && !sfr_write ##1 $stable(module_irq_enable)
		|-> irq_request)
		else $error("request dropped without a write");
	AST_RSVD_RF: assert property ($past(sfr_addr) == 8'hD8 |-> sfr_rdata[5:3] == 3'h0)
		else $error("unused control bits read nonzero");
	AST_RSVD_MD: assert property ($past(sfr_addr) == 8'hD9 |-> sfr_rdata[4] == 1'b0)
		else $error("unused mode bit read nonzero");
	// Main scenarios
	COV_WRAP: cover property (counter_tick && counter_value == 16'hFFFF);
	COV_WDT_OFF: cover property ($fell(watchdog_enable));
	COV_IRQ: cover property ($rose(irq_request));
endmodule
bind cacm_top cacm_assertions #(.COUNT_WIDTH(COUNT_WIDTH), .MODULES(MODULES)) i_cacm_assertions (
	.clk, .reset_n, .sfr_addr, .sfr_write, .sfr_wdata, .sfr_rdata, .module_event,
	.module_irq_enable, .cpu_idle, .counter_value, .counter_tick, .counter_active,
	.watchdog_enable, .irq_request);
`default_nettype wire

// ==== dv/tb_cacm_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Register level bench for the counter array control block
module tb_cacm_top;
	logic        clk                  = 1'b0;
	logic        reset_n              = 1'b0;
	logic [7:0]  sfr_addr             = 8'h00;
	logic        sfr_write            = 1'b0;
	logic [7:0]  sfr_wdata            = 8'h00;
	logic [2:0]  module_event         = 3'h0;
	logic [2:0]  module_irq_enable    = 3'h7;
	logic        cpu_idle             = 1'b0;
	logic        timer0_overflow      = 1'b0;
	logic        external_count_input = 1'b0;
	logic        external_clock       = 1'b0;
	logic [7:0]  sfr_rdata;
	logic [15:0] counter_value;
	logic        counter_tick;
	logic        counter_active;
	logic        watchdog_enable;
	logic        watchdog_force_reset;
	logic        irq_request;
	int          n_mismatch           = 0;
	int          n_compared           = 0;
	int          ph                   = 0;
	int          t;
	int          exp_ticks [8]        = '{8, 24, 12, 24, 96, 3, 0, 0};

	always #4 clk = ~clk;

	cacm_top i_cacm_top (.clk, .reset_n, .sfr_addr, .sfr_write, .sfr_wdata, .sfr_rdata,
		.module_event, .module_irq_enable, .cpu_idle, .timer0_overflow,
		.external_count_input, .external_clock, .counter_value, .counter_tick,
		.counter_active, .watchdog_enable, .watchdog_force_reset, .irq_request);

	// ==========================================================
	// Compare, bus and stimulus tasks
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_write = 1'b1;
		sfr_wdata = d;
		@(negedge clk);
		sfr_write = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		sfr_addr = a;
		@(negedge clk);
		cmp(sfr_rdata, e);
	endtask
	// Runs the source patterns and counts ticks after a settling time
	task automatic run(input int n, output int cnt);
		cnt = 0;
		for (int i = 0; i < n + 16; i++) begin
			@(negedge clk);
			if (i >= 16 && counter_tick === 1'b1) cnt++;
			ph++;
			timer0_overflow = (ph % 8 == 0);
			external_count_input = ph[1];
			external_clock = ph[1];
		end
	endtask
	task automatic pulse(input logic [2:0] k);
		@(negedge clk);
		module_event = k;
		@(negedge clk);
		module_event = 3'h0;
	endtask
	task automatic do_reset();
		reset_n = 1'b0;
		repeat (16) @(negedge clk);
		reset_n = 1'b1;
	endtask
	task automatic done(input string s);
		$display("%s finished, %0d compared", s, n_compared);
	endtask
	task automatic print_verdict();
		$display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		do_reset();
		rd(8'hD8, 8'h00);
		rd(8'hD9, 8'h40);
		rd(8'hDA, 8'h00);
		cmp(counter_active, 1'b1);
		run(96, t);
		cmp(16'(t), 16'd8);
		wr(8'hD9, 8'hFF);
		rd(8'hD9, 8'h40);
		wr(8'hD9, 8'h00);
		rd(8'hD9, 8'h00);
		cmp(watchdog_enable, 1'b0);
		cmp(counter_active, 1'b0);
		run(96, t);
		cmp(16'(t), 16'd0);
		done("reset and watchdog");
		wr(8'hD8, 8'h40);
		for (int c = 0; c < 8; c++) begin
			wr(8'hD9, 8'(c * 2));
			run(96, t);
			cmp(16'(t), 16'(exp_ticks[c]));
		end
		wr(8'hD9, 8'h88);
		cpu_idle = 1'b1;
		run(96, t);
		cmp(16'(t), 16'd0);
		cmp(counter_active, 1'b0);
		cpu_idle = 1'b0;
		run(96, t);
		cmp(16'(t), 16'd96);
		done("timebase and idle");
		for (int k = 0; k < 3; k++) begin
			pulse(3'(1 << k));
			repeat (8) @(negedge clk);
			rd(8'hD8, 8'(8'h40 | (1 << k)));
			cmp(irq_request, 1'b1);
			wr(8'hD8, 8'h40);
			cmp(irq_request, 1'b0);
		end
		@(negedge clk);
		sfr_addr = 8'hD8;
		sfr_write = 1'b1;
		sfr_wdata = 8'h40;
		module_event = 3'h1;
		@(negedge clk);
		sfr_write = 1'b0;
		module_event = 3'h0;
		rd(8'hD8, 8'h41);
		module_irq_enable = 3'h6;
		@(negedge clk);
		cmp(irq_request, 1'b0);
		module_irq_enable = 3'h7;
		wr(8'hD8, 8'h78);
		rd(8'hD8, 8'h40);
		wr(8'hD9, 8'h10);
		rd(8'hD9, 8'h00);
		done("flags");
		wr(8'hD9, 8'h09);
		cmp(irq_request, 1'b0);
		for (int i = 0; i < 70000 && counter_value !== 16'hFFFF; i++) @(negedge clk);
		if (counter_value !== 16'hFFFF) begin
			n_mismatch++;
			$display("ERROR %0t: counter never reached all ones", $time);
		end
		@(negedge clk);
		cmp(counter_value, 16'h0000);
		cmp(irq_request, 1'b1);
		rd(8'hD8, 8'hC0);
		wr(8'hD9, 8'h08);
		cmp(irq_request, 1'b0);
		wr(8'hD8, 8'h40);
		rd(8'hD8, 8'h40);
		done("overflow");
		wr(8'hD9, 8'h20);
		rd(8'hD9, 8'h60);
		wr(8'hD9, 8'h00);
		rd(8'hD9, 8'h60);
		cmp(watchdog_enable, 1'b1);
		do_reset();
		rd(8'hD9, 8'h40);
		wr(8'hD8, 8'h04);
		cmp(watchdog_force_reset, 1'b1);
		wr(8'hD8, 8'h00);
		cmp(watchdog_force_reset, 1'b0);
		cmp(counter_active, 1'b1);
		wr(8'hD9, 8'h00);
		rd(8'hD9, 8'h00);
		done("lock");
		print_verdict();
	end
endmodule
`default_nettype wire
